// file: pkg/csr_pkg.sv
`default_nettype none
// =====================================================================
// shared constants for the charger setting register bank
// =====================================================================
package csr_pkg;
   // bus address and command codes
   localparam logic [6:0] SLAVE_ADDR = 7'h09;
   localparam logic [7:0] CMD_CURRENT = 8'h14;
   localparam logic [7:0] CMD_VOLTAGE = 8'h15;
   localparam logic [15:0] CURRENT_RESET = 16'h0000;
   localparam logic [15:0] VOLTAGE_RESET = 16'h0000;
   // used weight bits; a masked word equals its value in mV or mA
   localparam logic [15:0] VOLT_MASK = 16'h7ff0;
   localparam logic [15:0] CURR_MASK = 16'h1f80;
   // valid ranges, mV and mA
   localparam logic [15:0] VOLT_MIN_MV = 16'h0400;
   localparam logic [15:0] VOLT_MAX_MV = 16'h4b00;
   localparam logic [15:0] CURR_MIN_MA = 16'h0080;
   localparam logic [15:0] CURR_MAX_MA = 16'h1f80;
   // foldback thresholds on the battery voltage, mV, and limits, mA
   localparam logic [15:0] FOLD_HI_MV = 16'h0e10;
   localparam logic [15:0] FOLD_LO_MV = 16'h09c4;
   localparam logic [15:0] FOLD_EXIT_MV = 16'h0a8c;
   localparam logic [15:0] FOLD_CLAMP_MA = 16'h0bb8;
   localparam logic [15:0] FOLD_TRICKLE_MA = 16'h00dc;
   // bus timing: 100 kHz bit rate, quarter-bit ticks at 125 MHz
   localparam int SYS_CLK_KHZ = 125000;
   localparam int BUS_KHZ = 100;
   localparam int QUARTER_CYC = SYS_CLK_KHZ / (BUS_KHZ * 4);

   // a command this bank answers to
   function automatic logic csr_cmd_ok(input logic [7:0] cmd);
      return (cmd == CMD_CURRENT) || (cmd == CMD_VOLTAGE);
   endfunction
endpackage
`default_nettype wire

// file: pkg/csr_smbus_if.sv
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// two-wire bus between host and charger, open-drain resolved here
// =====================================================================
interface csr_smbus_if;
   logic scl;
   logic sda;
   logic m_scl_o;
   logic m_scl_oe;
   logic m_sda_o;
   logic m_sda_oe;
   logic s_scl_o;
   logic s_scl_oe;
   logic s_sda_o;
   logic s_sda_oe;
   // pull-up wins unless someone drives low
   assign scl = ~((m_scl_oe & ~m_scl_o) | (s_scl_oe & ~s_scl_o));
   assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));
   modport master (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input scl, sda);
   modport slave (output s_scl_o, s_scl_oe, s_sda_o, s_sda_oe, input scl, sda);
endinterface
`default_nettype wire

// file: design/csr_sync2.sv
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// two-flop synchroniser for a pin level
// =====================================================================
module csr_sync2 (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic pin,
   output logic level
);
   logic meta_q;
   // resets high to match an idle pulled-up bus line
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 1'b1;
         level <= 1'b1;
      end else begin
         meta_q <= pin;
         level <= meta_q;
      end
   end
endmodule
`default_nettype wire

// file: design/csr_charger_dev.sv
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - word read: address write, command, restart, read
// - receiver acknowledges low in ninth clock
// - master sets read bit after restart
// - low byte first, master nacks high byte
// - voltage setting written with command 0x15
// - voltage valid 1.024 to 19.2 V
// - out-of-range voltage clears setting, stops charge
// - voltage bits 4-14 weigh 16 mV upward
// - reset clears both; wait for both writes
// - switch drives off until charging starts
// - current setting written with command 0x14
// - current valid 128 mA to 8.064 A
// - zero or out-of-range current stops charging
// - current bits 7-12 weigh 128 mA upward
// - battery 2.5-3.6 V clamps current to 3 A
// - below 2.5 V force 220 mA until 2.7 V
// - stored current kept during foldback, then reused
// - slave only, address 0x12, never initiates
// - word write: address, command, low, high, acked
module csr_charger_dev (
   input wire logic sys_clk,
   input wire logic rst_n,
   csr_smbus_if.slave bus,
   input wire logic [15:0] battery_sense_input,
   output logic charge_on,
   output logic hs_drive_en,
   output logic ls_drive_en,
   output logic [15:0] target_mv,
   output logic [15:0] current_ma,
   output logic [15:0] battery_target_level,
   output logic [15:0] battery_current_limit
);
   typedef enum logic [2:0] {
      CSR_IDLE = 3'b000,
      CSR_RX = 3'b001,
      CSR_ACK = 3'b010,
      CSR_TX = 3'b011,
      CSR_RACK = 3'b100
   } csr_state_t;

   // =====================================================================
   // pin sampling and bus events
   // =====================================================================
   logic scl_s, sda_s, scl_d_q, sda_d_q;
   logic scl_rise, scl_fall, start_ev, stop_ev;

   csr_sync2 u_scl (.sys_clk(sys_clk), .rst_n(rst_n), .pin(bus.scl), .level(scl_s));
   csr_sync2 u_sda (.sys_clk(sys_clk), .rst_n(rst_n), .pin(bus.sda), .level(sda_s));

   // delayed copies for edge detection, taken after the synchroniser
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_d_q <= 1'b1;
         sda_d_q <= 1'b1;
      end else begin
         scl_d_q <= scl_s;
         sda_d_q <= sda_s;
      end
   end

   assign scl_rise = scl_s & ~scl_d_q;
   assign scl_fall = ~scl_s & scl_d_q;
   assign start_ev = scl_s & scl_d_q & sda_d_q & ~sda_s;
   assign stop_ev = scl_s & scl_d_q & ~sda_d_q & sda_s;

   // the slave never drives the clock, and only ever pulls data low
   assign bus.s_scl_o = 1'b0;
   assign bus.s_scl_oe = 1'b0;
   assign bus.s_sda_o = 1'b0;

   // =====================================================================
   // byte-level slave engine
   // =====================================================================
   csr_state_t state_q;
   logic [7:0] sr_q;
   logic [3:0] bit_q;
   logic [1:0] idx_q;
   logic rd_q, hi_q, sda_oe_q;
   logic [7:0] cmd_q, lo_q;
   logic commit_q;
   logic [15:0] rd_word;

   // read-back shows only the weight bits
   assign rd_word = (cmd_q == csr_pkg::CMD_CURRENT) ? battery_current_limit
                                                      : battery_target_level;
   assign bus.s_sda_oe = sda_oe_q;

   // sequencing of address, command and data bytes; any start restarts
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= CSR_IDLE;
         sr_q <= 8'h00;
         bit_q <= 4'h0;
         idx_q <= 2'd0;
         rd_q <= 1'b0;
         hi_q <= 1'b0;
         sda_oe_q <= 1'b0;
         cmd_q <= 8'h00;
         lo_q <= 8'h00;
         commit_q <= 1'b0;
      end else begin
         commit_q <= 1'b0;
         if (start_ev) begin
            state_q <= CSR_RX;
            bit_q <= 4'h0;
            idx_q <= 2'd0;
            sda_oe_q <= 1'b0;
         end else if (stop_ev) begin
            state_q <= CSR_IDLE;
            sda_oe_q <= 1'b0;
         end else begin
            unique case (state_q)
               CSR_IDLE: begin
                  sda_oe_q <= 1'b0;
               end
               CSR_RX: begin
                  if (scl_rise) begin
                     sr_q <= {sr_q[6:0], sda_s};
                     bit_q <= bit_q + 4'h1;
                  end else if (scl_fall && bit_q == 4'h8) begin
                     bit_q <= 4'h0;
                     state_q <= CSR_IDLE;
                     unique case (idx_q)
                        2'd0: begin
                           // only our own address is acknowledged
                           if (sr_q[7:1] == csr_pkg::SLAVE_ADDR) begin
                              rd_q <= sr_q[0];
                              state_q <= CSR_ACK;
                              sda_oe_q <= 1'b1;
                           end
                        end
                        2'd1: begin
                           if (!rd_q && csr_pkg::csr_cmd_ok(sr_q)) begin
                              cmd_q <= sr_q;
                              state_q <= CSR_ACK;
                              sda_oe_q <= 1'b1;
                           end
                        end
                        2'd2: begin
                           lo_q <= sr_q;
                           state_q <= CSR_ACK;
                           sda_oe_q <= 1'b1;
                        end
                        2'd3: begin
                           commit_q <= 1'b1;
                           state_q <= CSR_ACK;
                           sda_oe_q <= 1'b1;
                        end
                     endcase
                  end
               end
               CSR_ACK: begin
                  // release after the ninth clock, then read or receive
                  if (scl_fall) begin
                     idx_q <= idx_q + 2'd1;
                     if (rd_q) begin
                        state_q <= CSR_TX;
                        hi_q <= 1'b0;
                        sr_q <= rd_word[7:0];
                        sda_oe_q <= ~rd_word[7];
                     end else begin
                        state_q <= CSR_RX;
                        sda_oe_q <= 1'b0;
                     end
                  end
               end
               CSR_TX: begin
                  if (scl_fall) begin
                     bit_q <= bit_q + 4'h1;
                     if (bit_q == 4'h7) begin
                        bit_q <= 4'h0;
                        sda_oe_q <= 1'b0;
                        state_q <= CSR_RACK;
                     end else begin
                        sr_q <= {sr_q[6:0], 1'b0};
                        sda_oe_q <= ~sr_q[6];
                     end
                  end
               end
               CSR_RACK: begin
                  // master ack after low byte sends high, nack ends it
                  if (scl_rise) begin
                     if (sda_s || hi_q) begin
                        state_q <= CSR_IDLE;
                     end
                  end else if (scl_fall) begin
                     state_q <= CSR_TX;
                     hi_q <= 1'b1;
                     sr_q <= rd_word[15:8];
                     sda_oe_q <= ~rd_word[15];
                  end
               end
               default: begin
                  state_q <= CSR_IDLE;
                  sda_oe_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // =====================================================================
   // setting registers
   // =====================================================================
   logic [15:0] wr_word;
   logic v_set_q, i_set_q;
   assign wr_word = {sr_q, lo_q};

   // range checks; a masked word is already the value in mV or mA
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         battery_target_level <= csr_pkg::VOLTAGE_RESET;
         battery_current_limit <= csr_pkg::CURRENT_RESET;
         v_set_q <= 1'b0;
         i_set_q <= 1'b0;
      end else if (commit_q && cmd_q == csr_pkg::CMD_VOLTAGE) begin
         v_set_q <= 1'b1;
         if ((wr_word & csr_pkg::VOLT_MASK) < csr_pkg::VOLT_MIN_MV ||
             (wr_word & csr_pkg::VOLT_MASK) > csr_pkg::VOLT_MAX_MV) begin
            battery_target_level <= 16'h0000;
         end else begin
            battery_target_level <= wr_word & csr_pkg::VOLT_MASK;
         end
      end else if (commit_q && cmd_q == csr_pkg::CMD_CURRENT) begin
         i_set_q <= 1'b1;
         // a zero or sub-step value lands on zero, which ends charging
         if ((wr_word & csr_pkg::CURR_MASK) < csr_pkg::CURR_MIN_MA ||
             (wr_word & csr_pkg::CURR_MASK) > csr_pkg::CURR_MAX_MA) begin
            battery_current_limit <= 16'h0000;
         end else begin
            battery_current_limit <= wr_word & csr_pkg::CURR_MASK;
         end
      end
   end

   // =====================================================================
   // charge qualification and current foldback
   // =====================================================================
   logic low_batt_q;

   // hysteresis keeps trickle mode from chattering near 2.5 V
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         low_batt_q <= 1'b0;
      end else if (battery_sense_input < csr_pkg::FOLD_LO_MV) begin
         low_batt_q <= 1'b1;
      end else if (battery_sense_input > csr_pkg::FOLD_EXIT_MV) begin
         low_batt_q <= 1'b0;
      end
   end

   // both settings must be written and non-zero; drives follow
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         charge_on <= 1'b0;
         hs_drive_en <= 1'b0;
         ls_drive_en <= 1'b0;
      end else begin
         charge_on <= v_set_q & i_set_q & (battery_target_level != 16'h0000) &
                      (battery_current_limit != 16'h0000);
         hs_drive_en <= charge_on;
         ls_drive_en <= charge_on;
      end
   end

   // limit only the regulation target; the stored word is untouched
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         target_mv <= 16'h0000;
         current_ma <= 16'h0000;
      end else begin
         target_mv <= charge_on ? battery_target_level : 16'h0000;
         if (!charge_on) begin
            current_ma <= 16'h0000;
         end else if (low_batt_q) begin
            current_ma <= csr_pkg::FOLD_TRICKLE_MA;
         end else if (battery_sense_input < csr_pkg::FOLD_HI_MV &&
                      battery_current_limit > csr_pkg::FOLD_CLAMP_MA) begin
            current_ma <= csr_pkg::FOLD_CLAMP_MA;
         end else begin
            current_ma <= battery_current_limit;
         end
      end
   end
endmodule
`default_nettype wire

// file: design/csr_host_ctl.sv
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// bus master issuing word writes and word reads to the charger
// =====================================================================
module csr_host_ctl #(
   parameter int QUARTER = csr_pkg::QUARTER_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   csr_smbus_if.master bus,
   input wire logic req,
   input wire logic req_read,
   input wire logic [7:0] req_cmd,
   input wire logic [15:0] req_data,
   output logic busy,
   output logic done,
   output logic [15:0] rsp_data,
   output logic rsp_nack
);
   typedef enum logic [1:0] {
      CSR_H_IDLE = 2'b00,
      CSR_H_START = 2'b01,
      CSR_H_BITS = 2'b10,
      CSR_H_STOP = 2'b11
   } csr_hstate_t;

   logic sda_s;
   logic [15:0] div_q;
   logic tick;
   csr_hstate_t st_q;
   logic [1:0] ph_q;
   logic [3:0] bit_q;
   logic [2:0] idx_q;
   logic rd_q, scl_oe_q, sda_oe_q;
   logic [7:0] cmd_q, rx_q;
   logic [15:0] data_q;
   logic tx_byte, tx_bit;
   logic [7:0] tb;

   csr_sync2 u_sda (.sys_clk(sys_clk), .rst_n(rst_n), .pin(bus.sda), .level(sda_s));

   assign bus.m_scl_o = 1'b0;
   assign bus.m_sda_o = 1'b0;
   assign bus.m_scl_oe = scl_oe_q;
   assign bus.m_sda_oe = sda_oe_q;
   assign busy = (st_q != CSR_H_IDLE);

   // quarter-bit enable; the rate divider keeps one clock domain
   assign tick = (div_q == 16'(QUARTER - 1));
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_q <= 16'h0000;
      end else begin
         div_q <= (tick || !busy) ? 16'h0000 : div_q + 16'h0001;
      end
   end

   // byte 2 is the repeated address with read bit; 3 and 4 are received
   assign tx_byte = !(rd_q && idx_q >= 3'd3);
   always_comb begin
      unique case (idx_q)
         3'd0: tb = {csr_pkg::SLAVE_ADDR, 1'b0};
         3'd1: tb = cmd_q;
         3'd2: tb = rd_q ? {csr_pkg::SLAVE_ADDR, 1'b1} : data_q[7:0];
         3'd3: tb = data_q[15:8];
         default: tb = 8'hff;
      endcase
   end
   // our ack after the low byte, nack after the high byte
   assign tx_bit = (bit_q == 4'h8) ? !(tx_byte == 1'b0 && idx_q == 3'd3)
                                   : (tx_byte ? tb[3'(4'h7 - bit_q)] : 1'b1);

   // four phases per bit: set data, raise clock, sample, lower clock
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= CSR_H_IDLE;
         ph_q <= 2'd0;
         bit_q <= 4'h0;
         idx_q <= 3'd0;
         rd_q <= 1'b0;
         cmd_q <= 8'h00;
         data_q <= 16'h0000;
         rx_q <= 8'h00;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
         done <= 1'b0;
         rsp_data <= 16'h0000;
         rsp_nack <= 1'b0;
      end else begin
         done <= 1'b0;
         if (st_q == CSR_H_IDLE) begin
            if (req) begin
               st_q <= CSR_H_START;
               ph_q <= 2'd0;
               idx_q <= 3'd0;
               rd_q <= req_read;
               cmd_q <= req_cmd;
               data_q <= req_data;
               rsp_nack <= 1'b0;
            end
         end else if (tick) begin
            ph_q <= ph_q + 2'd1;
            unique case (st_q)
               CSR_H_START: begin
                  // also serves as the repeated start before a read
                  unique case (ph_q)
                     2'd0: sda_oe_q <= 1'b0;
                     2'd1: scl_oe_q <= 1'b0;
                     2'd2: sda_oe_q <= 1'b1;
                     2'd3: begin
                        scl_oe_q <= 1'b1;
                        st_q <= CSR_H_BITS;
                        bit_q <= 4'h0;
                     end
                  endcase
               end
               CSR_H_BITS: begin
                  unique case (ph_q)
                     2'd0: sda_oe_q <= ~tx_bit;
                     2'd1: scl_oe_q <= 1'b0;
                     2'd2: begin
                        if (bit_q == 4'h8 && tx_byte && sda_s) begin
                           rsp_nack <= 1'b1;
                        end
                        if (bit_q < 4'h8) begin
                           rx_q <= {rx_q[6:0], sda_s};
                        end
                     end
                     2'd3: begin
                        scl_oe_q <= 1'b1;
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == 4'h8) begin
                           bit_q <= 4'h0;
                           idx_q <= idx_q + 3'd1;
                           if (!tx_byte && idx_q == 3'd3) begin
                              rsp_data[7:0] <= rx_q;
                           end else if (!tx_byte) begin
                              rsp_data[15:8] <= rx_q;
                           end
                           if (rsp_nack || (!rd_q && idx_q == 3'd3) ||
                               (rd_q && idx_q == 3'd4)) begin
                              st_q <= CSR_H_STOP;
                           end else if (rd_q && idx_q == 3'd1) begin
                              st_q <= CSR_H_START;
                           end
                        end
                     end
                  endcase
               end
               CSR_H_STOP: begin
                  unique case (ph_q)
                     2'd0: sda_oe_q <= 1'b1;
                     2'd1: scl_oe_q <= 1'b0;
                     2'd2: sda_oe_q <= 1'b0;
                     2'd3: begin
                        st_q <= CSR_H_IDLE;
                        done <= 1'b1;
                     end
                  endcase
               end
               default: st_q <= CSR_H_IDLE;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// file: dv/csr_props.sv
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// bus wire and setting checks
// =====================================================================
module csr_props (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic scl,
   input wire logic s_scl_oe,
   input wire logic s_sda_oe,
   input wire logic charge_on,
   input wire logic hs_drive_en,
   input wire logic ls_drive_en,
   input wire logic [15:0] target_mv,
   input wire logic [15:0] current_ma,
   input wire logic [15:0] battery_target_level,
   input wire logic [15:0] battery_current_limit,
   input wire logic [15:0] battery_sense_input
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // foldback needs the level to settle through flag and output flops
   sequence s_trickle;
      (charge_on && battery_sense_input < csr_pkg::FOLD_LO_MV) [*4];
   endsequence
   sequence s_clamp;
      (charge_on && battery_sense_input > csr_pkg::FOLD_EXIT_MV
       && battery_sense_input < csr_pkg::FOLD_HI_MV) [*4];
   endsequence
   a_slave_no_clock: assert property (s_scl_oe == 1'b0)
      else $error("slave drove the clock line");
   a_sda_scl_high: assert property (scl && $past(scl) |-> $stable(s_sda_oe))
      else $error("slave moved data while clock high");
   a_drives_held_off: assert property (!charge_on ##1 !charge_on |-> !hs_drive_en && !ls_drive_en)
      else $error("switch drive on while charging off");
   a_outputs_gated: assert property (!charge_on |=> target_mv == 16'h0000 && current_ma == 16'h0000)
      else $error("setting outputs live while off");
   a_volt_unused_zero: assert property ((battery_target_level & ~csr_pkg::VOLT_MASK) == 16'h0000)
      else $error("voltage unused bits set");
   a_curr_unused_zero: assert property ((battery_current_limit & ~csr_pkg::CURR_MASK) == 16'h0000)
      else $error("current unused bits set");
   a_volt_in_range: assert property (battery_target_level == 16'h0000 || (battery_target_level >= csr_pkg::VOLT_MIN_MV && battery_target_level <= csr_pkg::VOLT_MAX_MV))
      else $error("voltage setting out of range");
   a_on_needs_both: assert property (charge_on |-> $past(battery_current_limit) != 16'h0000 && $past(battery_target_level) != 16'h0000)
      else $error("charging with a cleared setting");
   a_trickle_force: assert property (s_trickle |=> current_ma == csr_pkg::FOLD_TRICKLE_MA)
      else $error("low battery current not forced");
   a_clamp_limit: assert property (s_clamp |=> current_ma <= csr_pkg::FOLD_CLAMP_MA)
      else $error("mid battery current not clamped");
endmodule
`default_nettype wire

// file: dv/charger_setting_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// host and charger joined over the bus
// =====================================================================
module charger_setting_regs_tb;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic req = 1'b0;
   logic req_read = 1'b0;
   logic [7:0] req_cmd = 8'h00;
   logic [15:0] req_data = 16'h0000;
   logic [15:0] vbat = 16'h0fa0;
   logic busy, done, rsp_nack, charge_on, hs_drive_en, ls_drive_en;
   logic [15:0] rsp_data, target_mv, current_ma, volt_w, curr_w, w;
   logic [7:0] sh = 8'h00;
   logic [7:0] first_b = 8'h00;
   logic [15:0] fb_v [5] = '{16'h0bb8, 16'h07d0, 16'h0a28, 16'h0af0, 16'h0fa0};
   logic [15:0] fb_e [5] = '{16'h0bb8, 16'h00dc, 16'h00dc, 16'h0bb8, 16'h1f80};
   logic [15:0] cw [6] = '{16'h03f0, 16'h0400, 16'h4b00, 16'h4b10, 16'hffff, 16'h007f};
   int n_fail = 0;
   int n_tests = 0;
   int nb = 0;
   int seed = 32'h452e533a;
   csr_smbus_if csr_smbus_if_i ();
   csr_charger_dev csr_charger_dev_i (.sys_clk(sys_clk), .rst_n(rst_n),
      .bus(csr_smbus_if_i.slave), .battery_sense_input(vbat), .charge_on(charge_on),
      .hs_drive_en(hs_drive_en), .ls_drive_en(ls_drive_en), .target_mv(target_mv),
      .current_ma(current_ma), .battery_target_level(volt_w), .battery_current_limit(curr_w));
   // short quarter keeps a write near 600 cycles and a read near 770
   csr_host_ctl #(.QUARTER(4)) csr_host_ctl_i (.sys_clk(sys_clk), .rst_n(rst_n),
      .bus(csr_smbus_if_i.master), .req(req), .req_read(req_read), .req_cmd(req_cmd),
      .req_data(req_data), .busy(busy), .done(done), .rsp_data(rsp_data), .rsp_nack(rsp_nack));
   csr_props csr_props_i (.sys_clk(sys_clk), .rst_n(rst_n), .scl(csr_smbus_if_i.scl),
      .s_scl_oe(csr_smbus_if_i.s_scl_oe), .s_sda_oe(csr_smbus_if_i.s_sda_oe),
      .charge_on(charge_on), .hs_drive_en(hs_drive_en), .ls_drive_en(ls_drive_en),
      .target_mv(target_mv), .current_ma(current_ma), .battery_target_level(volt_w),
      .battery_current_limit(curr_w), .battery_sense_input(vbat));
   always #4 sys_clk = ~sys_clk;
   // wire monitor: first byte after each start, msb first
   always @(negedge csr_smbus_if_i.sda) if (csr_smbus_if_i.scl) nb = 0;
   always @(posedge csr_smbus_if_i.scl) begin
      nb++;
      sh = {sh[6:0], csr_smbus_if_i.sda};
      if (nb == 8) first_b = sh;
   end
   // expected stored words; out-of-range voltage clears
   function automatic logic [15:0] exp_volt(input logic [15:0] v);
      logic [15:0] m;
      m = v & csr_pkg::VOLT_MASK;
      return (m < csr_pkg::VOLT_MIN_MV || m > csr_pkg::VOLT_MAX_MV) ? 16'h0000 : m;
   endfunction
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one host request, bounded wait for done, then settle time
   task automatic xfer(input logic rd, input logic [7:0] cmd, input logic [15:0] d);
      int k;
      @(negedge sys_clk);
      req = 1'b1;
      req_read = rd;
      req_cmd = cmd;
      req_data = d;
      @(negedge sys_clk);
      req = 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 1200) begin
         @(negedge sys_clk);
         k++;
      end
      if (k >= 1200) n_fail++;
      repeat (6) @(negedge sys_clk);
      chk("busy", {15'h0, busy}, 16'h0000);
   endtask
   task automatic wr_rd(input logic [7:0] cmd, input logic [15:0] d, input logic [15:0] e);
      xfer(1'b0, cmd, d);
      chk("write nack", {15'h0, rsp_nack}, 16'h0000);
      chk("addr w", {8'h0, first_b}, {8'h0, csr_pkg::SLAVE_ADDR, 1'b0});
      chk("stored", (cmd == csr_pkg::CMD_VOLTAGE) ? volt_w : curr_w, e);
      xfer(1'b1, cmd, 16'h0000);
      chk("read nack", {15'h0, rsp_nack}, 16'h0000);
      chk("addr r", {8'h0, first_b}, {8'h0, csr_pkg::SLAVE_ADDR, 1'b1});
      chk("read back", rsp_data, e);
      chk("idle lines", {14'h0, csr_smbus_if_i.scl, csr_smbus_if_i.sda}, 16'h0003);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // watchdog sized well above the expected run
   initial begin
      #520000;
      n_fail++;
      report_and_stop;
   end
   initial begin
      repeat (12) @(posedge sys_clk);
      @(negedge sys_clk);
      rst_n = 1'b1;
      repeat (4) @(negedge sys_clk);
      chk("volt reset", volt_w, csr_pkg::VOLTAGE_RESET);
      chk("curr reset", curr_w, csr_pkg::CURRENT_RESET);
      chk("drives", {14'h0, hs_drive_en, ls_drive_en}, 16'h0000);
      $display("test reset done");
      // voltage alone must not start charging
      wr_rd(csr_pkg::CMD_VOLTAGE, 16'h8ff7, 16'h0ff0);
      chk("on early", {15'h0, charge_on}, 16'h0000);
      wr_rd(csr_pkg::CMD_CURRENT, 16'hffff, 16'h1f80);
      chk("drives on", {13'h0, charge_on, hs_drive_en, ls_drive_en}, 16'h0007);
      chk("target", target_mv, 16'h0ff0);
      $display("test start done");
      // clamp, trickle, hysteresis band, release
      for (int i = 0; i < 5; i++) begin
         vbat = fb_v[i];
         repeat (8) @(negedge sys_clk);
         chk("fold", current_ma, fb_e[i]);
      end
      chk("kept", curr_w, 16'h1f80);
      $display("test foldback done");
      // corner words first, then random ones
      for (int i = 0; i < 14; i++) begin
         w = (i < 6) ? cw[i] : 16'($random(seed));
         wr_rd(csr_pkg::CMD_VOLTAGE, w, exp_volt(w));
         w = (i < 6) ? cw[i] : 16'($random(seed));
         wr_rd(csr_pkg::CMD_CURRENT, w, w & csr_pkg::CURR_MASK);
      end
      $display("test ranges done");
      wr_rd(csr_pkg::CMD_CURRENT, 16'h0000, 16'h0000);
      chk("stopped", {15'h0, charge_on}, 16'h0000);
      chk("current out", current_ma, 16'h0000);
      xfer(1'b0, 8'h3f, 16'h1234);
      chk("unmapped nack", {15'h0, rsp_nack}, 16'h0001);
      $display("test stop done");
      report_and_stop;
   end
endmodule
`default_nettype wire
